// file: hw/agc_gain_ctrl.v
// Gain control sequencer with start-up, shutdown and Wishbone registers
//
// Function
// [R1] Gain decrement only after attack interval elapsed since last change.
// [R2] Gain increment only after release interval elapsed since last change.
// [R3] Every loop gain change restarts all interval counting from zero.
// [R4] First increment after decrement waits hold if enabled and longer.
// [R5] Hold disabled: release interval used for every increment.
// [R6] Envelope below noise gate threshold freezes gain until it rises.
// [R7] Maximum gain caps the steps available to the loop.
// [R8] Compression gain change is input change times one minus 1/ratio.
// [R9] Compression curve pivots at 10 dBV; fixed gain shifts output only.
// [R10] Enable pin high powers control logic with registers at defaults.
// [R11] After enable rises, active mode; output stage on 5 ms later.
// [R12] Hardware start begins at default fixed gain; loop waits for gate.
// [R13] Leaving software shutdown starts at latest fixed gain immediately.
// [R14] Fixed gain written during playback is reached by stepping.
// [R15] Enable low with shutdown clear holds gain at fixed gain.
// [R16] Clearing amplifier enable bit disables only the output stage.
// [R17] Setting software shutdown bit disables most amplifier functions.
// [R18] Enable pin low shuts down and restores register defaults.
// [R19] Host must not interrupt a start-up sequence once begun.
// [R20] Host must not interrupt a shutdown sequence once begun.
// [R21] Host should keep attack 100x below release and hold.
// [R22] Each loop gain change is one 0.5 dB step.
// [R23] Fixed gain spans -28..30 dB compressing, else 0..30 dB.
// [R24] Decrement above target output level, increment below it.
// [R25] Applied gain clamped between lowest step and maximum gain.
`timescale 1ns/1ps
`default_nettype none
`include "agc_regs.vh"

module agc_gain_ctrl #(
  parameter STARTUP_CYC = `STARTUP_MS * `CLK_KHZ,
  parameter TICK_CYC    = `TICK_US * `CLK_KHZ / 1000
)(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        en_i,
  input  wire [7:0]  env_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg  [7:0]  gain_o,
  output reg         amp_on_o,
  output reg         ctrl_on_o
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [7:0]        ctrl_reg;
  reg  [5:0]        attack_reg;
  reg  [5:0]        release_reg;
  reg  [5:0]        hold_reg;
  reg  [5:0]        fixed_reg;
  reg  [5:0]        maxgain_reg;
  reg  [1:0]        ratio_reg;
  reg  [7:0]        limit_reg;
  reg  [7:0]        gate_reg;
  reg  signed [7:0] gain_reg;
  reg  [12:0]       ivl_reg;
  reg  [15:0]       pre_reg;
  reg  [19:0]       start_reg;
  reg               ready_reg;
  reg               after_dec_reg;
  reg               armed_reg;
  reg               shdn_d_reg;
  reg  [7:0]        rd_next;
  wire              pwr_rst;
  wire [3:0]        idx;
  wire              acc;
  wire              wr;
  wire              shdn;
  wire              tick;

  // Enable pin low acts as the full reset of control state
  assign pwr_rst = rst_i | ~en_i; // [R10] [R18]
  assign idx     = wb_adr_i[5:2];
  assign acc     = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wr      = acc & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign shdn    = ctrl_reg[`CTRL_SHDN];
  assign tick    = (pre_reg == TICK_CYC[15:0] - 16'h0001);

  ////////////////////////////////////////////////////////////////////////
  // Gain arithmetic in half-dB units

  reg  signed [9:0] env2;
  reg  signed [9:0] fix_db;
  reg  signed [9:0] fix2;
  reg  signed [9:0] delta;
  reg  signed [9:0] comp;
  reg  signed [9:0] tgt;
  reg  signed [9:0] max2;
  reg  signed [9:0] lim2;
  reg  signed [9:0] gain2;
  reg               gated;

  // Target gain from fixed gain, compression and limiter
  always @*
  begin
    env2  = {{2{env_i[7]}}, env_i};
    gain2 = {{2{gain_reg[7]}}, gain_reg};
    lim2  = {{2{limit_reg[7]}}, limit_reg};
    max2  = {3'h0, maxgain_reg, 1'b0};
    fix_db = {{4{fixed_reg[5]}}, fixed_reg};
    // Range narrows when compression is off
    if (ratio_reg != 2'h0 && fix_db < `FIX_MIN_COMP) // [R23]
      fix_db = `FIX_MIN_COMP;
    else if (ratio_reg == 2'h0 && fix_db < `FIX_MIN_PLAIN) // [R23]
      fix_db = `FIX_MIN_PLAIN;
    else if (fix_db > `FIX_MAX) // [R23]
      fix_db = `FIX_MAX;
    fix2  = fix_db <<< 1;
    // Pivot stays at the input axis; fixed gain only shifts output
    delta = (`PIVOT_DBV <<< 1) - env2; // [R9]
    comp  = delta - (delta >>> ratio_reg); // [R8]
    tgt   = fix2 + comp;
    // Limiter ceiling on output level
    if (env2 + tgt > lim2) // [R24]
      tgt = lim2 - env2;
    if (tgt > max2) // [R7] [R25]
      tgt = max2;
    if (tgt < `GAIN_MIN2) // [R25]
      tgt = `GAIN_MIN2;
    // Signed compare; an unsigned one would gate every positive envelope
    gated = ctrl_reg[`CTRL_GATE_EN] && (env2 <= $signed({{2{gate_reg[7]}}, gate_reg})); // [R6]
  end

  ////////////////////////////////////////////////////////////////////////
  // Interval timing

  reg        atk_done;
  reg        inc_done;
  reg [12:0] rel_lim;
  reg [12:0] hold_lim;

  // Increment wait picks hold only after a decrement
  always @*
  begin
    rel_lim  = {1'b0, release_reg, 6'h00};
    hold_lim = {1'b0, hold_reg, 6'h00};
    atk_done = (ivl_reg >= {7'h00, attack_reg}); // [R1]
    if (after_dec_reg && hold_reg != 6'h00 && hold_reg > release_reg) // [R4]
      inc_done = (ivl_reg >= hold_lim);
    else
      inc_done = (ivl_reg >= rel_lim); // [R2] [R5]
  end

  // Time base prescaler
  always @(posedge clk_i)
  begin
    if (pwr_rst || tick)
      pre_reg <= 16'h0000;
    else
      pre_reg <= pre_reg + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Start-up sequence

  // Output stage waits out the start-up delay after enable rises
  always @(posedge clk_i)
  begin
    if (pwr_rst)
    begin
      start_reg <= 20'h00000;
      ready_reg <= 1'b0;
    end
    else if (!ready_reg)
    begin
      if (start_reg == STARTUP_CYC[19:0] - 20'h00001) // [R11]
        ready_reg <= 1'b1;
      start_reg <= start_reg + 20'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gain loop

  // One half-dB step per change; counters restart on every change
  always @(posedge clk_i)
  begin
    if (pwr_rst)
    begin
      gain_reg      <= {1'b0, `RST_FIXED, 1'b0}; // [R12] [R15]
      ivl_reg       <= 13'h0000;
      after_dec_reg <= 1'b0;
      armed_reg     <= 1'b0;
      shdn_d_reg    <= 1'b0;
    end
    else
    begin
      shdn_d_reg <= shdn;
      // Loop only starts once signal clears the gate
      if (!gated)
        armed_reg <= 1'b1; // [R12]
      if (shdn)
      begin
        // Shutdown tracks fixed gain so release resumes there at once
        gain_reg      <= fix2[7:0]; // [R13] [R17]
        ivl_reg       <= 13'h0000;
        after_dec_reg <= 1'b0;
      end
      else if (gated || !armed_reg)
      begin
        // Frozen gain; timers still run so a step can follow quickly
        if (tick && ivl_reg != 13'h1fff) // [R6]
          ivl_reg <= ivl_reg + 13'h0001;
      end
      else if (gain2 > tgt && atk_done)
      begin
        gain_reg      <= gain_reg - 8'sd1; // [R22] [R24] [R14]
        ivl_reg       <= 13'h0000; // [R3]
        after_dec_reg <= 1'b1;
      end
      else if (gain2 < tgt && inc_done)
      begin
        gain_reg      <= gain_reg + 8'sd1; // [R22] [R24] [R14]
        ivl_reg       <= 13'h0000; // [R3]
        after_dec_reg <= 1'b0;
      end
      else if (tick && ivl_reg != 13'h1fff)
        ivl_reg <= ivl_reg + 13'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file

  // Software writes; pin reset restores every default
  always @(posedge clk_i)
  begin
    if (pwr_rst)
    begin
      ctrl_reg    <= `RST_CTRL; // [R10] [R18]
      attack_reg  <= `RST_ATTACK;
      release_reg <= `RST_RELEASE;
      hold_reg    <= `RST_HOLD;
      fixed_reg   <= `RST_FIXED;
      maxgain_reg <= `RST_MAXGAIN;
      ratio_reg   <= `RST_RATIO;
      limit_reg   <= `RST_LIMIT;
      gate_reg    <= `RST_GATE;
    end
    else if (wr)
    begin
      case (idx)
        `IDX_CTRL:
        begin
          ctrl_reg[`CTRL_AMP_EN]  <= wb_dat_i[`CTRL_AMP_EN]; // [R16]
          ctrl_reg[`CTRL_SHDN]    <= wb_dat_i[`CTRL_SHDN]; // [R17]
          ctrl_reg[`CTRL_GATE_EN] <= wb_dat_i[`CTRL_GATE_EN];
        end
        `IDX_ATTACK:  attack_reg  <= wb_dat_i[5:0];
        `IDX_RELEASE: release_reg <= wb_dat_i[5:0];
        `IDX_HOLD:    hold_reg    <= wb_dat_i[5:0];
        `IDX_FIXED:   fixed_reg   <= wb_dat_i[5:0];
        `IDX_MAXGAIN: maxgain_reg <= wb_dat_i[5:0];
        `IDX_RATIO:   ratio_reg   <= wb_dat_i[1:0];
        `IDX_LIMIT:   limit_reg   <= wb_dat_i[7:0];
        `IDX_GATE:    gate_reg    <= wb_dat_i[7:0];
        default:      ctrl_reg    <= ctrl_reg;
      endcase
    end
  end

  // Read mux; unmapped words read zero
  always @*
  begin
    case (idx)
      `IDX_CTRL:    rd_next = ctrl_reg;
      `IDX_ATTACK:  rd_next = {2'h0, attack_reg};
      `IDX_RELEASE: rd_next = {2'h0, release_reg};
      `IDX_HOLD:    rd_next = {2'h0, hold_reg};
      `IDX_FIXED:   rd_next = {2'h0, fixed_reg};
      `IDX_MAXGAIN: rd_next = {2'h0, maxgain_reg};
      `IDX_RATIO:   rd_next = {6'h00, ratio_reg};
      `IDX_LIMIT:   rd_next = limit_reg;
      `IDX_GATE:    rd_next = gate_reg;
      `IDX_STATUS:  rd_next = gain_reg;
      default:      rd_next = 8'h00;
    endcase
  end

  // Registered ack; every access answered, one cycle after the request
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= acc & ~wb_ack_o;
      if (acc && !wb_ack_o)
        wb_dat_o <= {24'h000000, rd_next};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Output stage needs start-up done, enable bit set and no shutdown
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gain_o    <= 8'h00;
      amp_on_o  <= 1'b0;
      ctrl_on_o <= 1'b0;
    end
    else
    begin
      gain_o    <= gain_reg;
      amp_on_o  <= ready_reg & ctrl_reg[`CTRL_AMP_EN] & ~shdn & en_i; // [R11] [R16] [R17]
      ctrl_on_o <= en_i; // [R10]
    end
  end

endmodule // agc_gain_ctrl
`default_nettype wire

// file: hw/agc_regs.vh
// Register map, field positions, reset values and timing for the gain sequencer
`ifndef AGC_REGS_VH
`define AGC_REGS_VH
// Word indexes; byte address is four times the index
`define IDX_CTRL      4'h1
`define IDX_ATTACK    4'h2
`define IDX_RELEASE   4'h3
`define IDX_HOLD      4'h4
`define IDX_FIXED     4'h5
`define IDX_MAXGAIN   4'h6
`define IDX_RATIO     4'h7
`define IDX_LIMIT     4'h8
`define IDX_GATE      4'h9
`define IDX_STATUS    4'ha
// Control register fields
`define CTRL_AMP_EN   6
`define CTRL_SHDN     5
`define CTRL_ONE      1
`define CTRL_GATE_EN  0
// Reset values
`define RST_CTRL      8'h43
`define RST_ATTACK    6'h05
`define RST_RELEASE   6'h0b
`define RST_HOLD      6'h00
`define RST_FIXED     6'h06
`define RST_MAXGAIN   6'h1e
`define RST_RATIO     2'h2
`define RST_LIMIT     8'h0f
`define RST_GATE      8'hb0
// Gain limits in dB and half-dB steps
`define FIX_MIN_COMP  (-10'sd28)
`define FIX_MIN_PLAIN 10'sd0
`define FIX_MAX       10'sd30
`define GAIN_MIN2     (-10'sd56)
// Compression pivot in dBV
`define PIVOT_DBV     10'sd10
// Timing
`define CLK_KHZ       50000
`define STARTUP_MS    5
`define TICK_US       100
`define REL_SHIFT     6
`endif

// file: tb/agc_gain_chk_sva.sv
// Port-level checker for the gain sequencer
`timescale 1ns/1ps
`default_nettype none
module agc_gain_chk #(
  parameter STARTUP_CYC = 20
)(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        en_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  gain_o,
  input wire logic        amp_on_o,
  input wire logic        ctrl_on_o
);
  logic [31:0] up_cnt;
  // Cycles since reset released with enable high; saturates so it never wraps
  always @(posedge clk_i)
  begin
    if (rst_i || !en_i)
      up_cnt <= 32'h0;
    else if (up_cnt != 32'hffffffff)
      up_cnt <= up_cnt + 32'h1;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  // Steps judged only while the stage runs; restarts may jump the gain
  sequence s_steady; (amp_on_o && en_i) [*3]; endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_rdata_high: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("read data high bits");
  a_reset_zero: assert property (disable iff (1'b0) rst_i |=> gain_o == 8'h00 && !wb_ack_o)
    else $error("outputs not cleared in reset");
  a_gain_step: assert property (s_steady |-> gain_o == $past(gain_o) ||
    gain_o == $past(gain_o) + 8'h01 ||
    gain_o == $past(gain_o) - 8'h01) else $error("gain moved more than one step");
  a_gain_range: assert property ($signed(gain_o) >= -56 && $signed(gain_o) <= 60)
    else $error("gain out of range");
  a_amp_startup: assert property ($rose(amp_on_o) |-> up_cnt >= STARTUP_CYC)
    else $error("output stage on early");
  a_amp_needs_en: assert property (!en_i [*3] |-> !amp_on_o && !ctrl_on_o)
    else $error("on while enable low");
  a_ctrl_rise: assert property ($rose(ctrl_on_o) |-> $past(en_i))
    else $error("control on without enable");
endmodule // agc_gain_chk
`default_nettype wire

// file: tb/wb_host_model.sv
// Host processor model: classic Wishbone master for register access
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output var  logic        cyc_o,
  output var  logic        stb_o,
  output var  logic        we_o,
  output var  logic [5:0]  adr_o,
  output var  logic [3:0]  sel_o,
  output var  logic [31:0] dat_o
);
  // Idle bus at time zero
  initial
  begin
    {cyc_o, stb_o, we_o, sel_o} = 7'h00;
    adr_o = 6'h00;
    dat_o = 32'h0;
  end
  // One transfer; request held until ack is sampled, lines scrambled after
  task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, sel_o} <= {2'b11, 4'hf};
    we_o  <= w;
    adr_o <= {idx, 2'b00};
    dat_o <= {24'h0, d};
    @(posedge clk_i);
    while (ack_i !== 1'b1)
      @(posedge clk_i);
    q = rdat_i[7:0];
    {cyc_o, stb_o, we_o, sel_o} <= 7'h00;
    adr_o <= ~{idx, 2'b00};
    dat_o <= ~{24'h0, d};
  endtask
endmodule // wb_host_model
`default_nettype wire

// file: tb/agc_gain_ctrl_tb.sv
// Self-checking bench for the gain sequencer
`timescale 1ns/1ps
`default_nettype none
module agc_gain_ctrl_tb;
  localparam int ST = 20;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        en_i  = 1'b1;
  logic [7:0]  env_i = 8'h80;
  logic        cyc, stb, we, ack, amp, con;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wd, rdat;
  logic [7:0]  gain, q;
  int          num_errors = 0;
  int          n_tests = 0;
  int          n;
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  agc_gain_ctrl #(.STARTUP_CYC(ST), .TICK_CYC(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i),
    .env_i(env_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .gain_o(gain), .amp_on_o(amp), .ctrl_on_o(con));
  wb_host_model host_u (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    host_u.xfer(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    host_u.xfer(1'b0, i, 8'h00, q);
    chk("register read", {24'h0, q}, {24'h0, e});
  endtask
  // Edges until gain moves, capped at 4000
  task automatic wait_move(output int c);
    logic [7:0] g;
    g = gain;
    c = 0;
    while (gain === g && c < 4000) begin @(posedge clk_i); c++; end
  endtask
  task automatic wait_amp(output int c);
    c = 0;
    while (amp !== 1'b1 && c < 200) begin @(posedge clk_i); c++; end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_defaults;
    logic [7:0] dv [11] = '{8'h00, 8'h43, 8'h05, 8'h0b, 8'h00, 8'h06, 8'h1e, 8'h02, 8'h0f, 8'hb0, 8'h0c};
    wait_amp(n);
    chk("startup delay", n >= ST && n <= ST + 4, 32'h1);
    for (int i = 0; i < 11; i++)
      rd(i[3:0], dv[i]);
    rd(4'hf, 8'h00);
    $display("defaults done");
  endtask
  task automatic t_loop;
    wr(4'h3, 8'h08);
    wr(4'h4, 8'h0c);
    env_i <= 8'h14;
    wait_move(n);
    chk("first decrement", gain, 8'h0b);
    wait_move(n);
    chk("attack gap", n > 16 && n <= 22, 32'h1);
    while (gain !== 8'hfb && n < 4000) wait_move(n);
    chk("limited gain", gain, 8'hfb);
    env_i <= 8'h00;
    wait_move(n);
    chk("hold gap", n > 3068 && n <= 3074, 32'h1);
    wait_move(n);
    chk("release gap", n > 2044 && n <= 2050, 32'h1);
    wr(4'h4, 8'h00);
    env_i <= 8'h14;
    wait_move(n);
    env_i <= 8'h00;
    wait_move(n);
    chk("release without hold", n > 2044 && n <= 2050, 32'h1);
    wr(4'h3, 8'h01);
    wr(4'h6, 8'h00);
    repeat (1500) @(posedge clk_i);
    chk("capped gain", gain, 8'h00);
    rd(4'ha, 8'h00);
    $display("loop timing done");
  endtask
  task automatic t_gate;
    wr(4'h9, 8'h10);
    wr(4'h6, 8'h1e);
    env_i <= 8'h08;
    wait_move(n);
    chk("gate freeze", n, 32'd4000);
    env_i <= 8'h11;
    wait_move(n);
    chk("gate reopen", n <= 8, 32'h1);
    $display("noise gate done");
  endtask
  task automatic t_power;
    wr(4'h1, 8'h63);
    repeat (3) @(posedge clk_i);
    chk("shutdown stage", amp, 1'b0);
    wr(4'h5, 8'h0c);
    repeat (2) @(posedge clk_i);
    wr(4'h1, 8'h43);
    chk("shutdown exit gain", gain, 8'h18);
    wait_amp(n);
    chk("shutdown exit stage", n <= 4, 32'h1);
    wr(4'h1, 8'h03);
    repeat (3) @(posedge clk_i);
    chk("amp bit off", {amp, con}, 2'b01);
    en_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("pin low", {amp, con}, 2'b00);
    chk("pin low gain", gain, 8'h0c);
    en_i <= 1'b1;
    wait_amp(n);
    chk("restart delay", n >= ST && n <= ST + 4, 32'h1);
    rd(4'h5, 8'h06);
    rd(4'h1, 8'h43);
    $display("power control done");
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_defaults;
    t_loop;
    t_gate;
    t_power;
    tally_and_finish;
  end
  // Watchdog well beyond the expected run of about 13000 cycles
  initial
  begin
    #1000000;
    num_errors++;
    tally_and_finish;
  end
endmodule // agc_gain_ctrl_tb
bind agc_gain_ctrl agc_gain_chk #(.STARTUP_CYC(STARTUP_CYC)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .en_i(en_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .gain_o(gain_o), .amp_on_o(amp_on_o), .ctrl_on_o(ctrl_on_o));
`default_nettype wire
